// ### verilog/uvol_regs.vh
// register offsets, fields and reset values for the undervoltage / open-load fault block
`ifndef UVOL_REGS_VH
`define UVOL_REGS_VH
`define UVOL_ADDR_CTRL      12'h000
`define UVOL_ADDR_STATUS    12'h004
`define UVOL_ADDR_IRQ_STAT  12'h008
`define UVOL_ADDR_IRQ_MASK  12'h00C
`define UVOL_ADDR_LIVE      12'h010
`define UVOL_ADDR_CHAIN     12'h014
// ctrl fields
`define UVOL_CTRL_CMD_LSB   0
`define UVOL_CTRL_UVOFF     4
`define UVOL_CTRL_OLOFF_LSB 8
`define UVOL_CTRL_RESET     32'h00000000
// status fields
`define UVOL_ST_OL_LSB      0
`define UVOL_ST_UV          4
// irq fields
`define UVOL_IRQ_UV         0
`define UVOL_IRQ_OL         1
`define UVOL_MASK_RESET     2'h0
// live fields
`define UVOL_LV_OUT_LSB     0
`define UVOL_LV_FAULT       4
`define UVOL_LV_UVLATCH     5
// gate discharge time before open-load is sampled
`define UVOL_GATE_OFF_NS    2000
`define UVOL_CLK_NS         8
`define UVOL_GATE_OFF_CYC   ((`UVOL_GATE_OFF_NS + `UVOL_CLK_NS - 1) / `UVOL_CLK_NS)
`define UVOL_GATE_CNT_W     9
`endif

// ### verilog/uvol_sync.v
// two-flop synchroniser for a vector of comparator levels
`timescale 1ns/10ps
module uvol_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ### verilog/uvol_fault.v
// undervoltage and open-load fault logic with apb register access
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "uvol_regs.vh"
module uvol_fault (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [3:0]  direct_in,
    input  wire        battery_uv,
    input  wire        battery_por,
    input  wire        battery_low25,
    input  wire [3:0]  open_load_cmp,
    input  wire        chain_si,
    input  wire        chain_shift,
    output reg         chain_so,
    output reg  [3:0]  output_enable,
    output reg         fault_flag_n,
    output wire        irq
);
    reg  [3:0]  cmd_spi;
    reg         undervoltage_protect_off;
    reg  [3:0]  open_load_detect_off;
    reg  [3:0]  open_load_flag;
    reg         undervoltage_flag;
    reg  [3:0]  uv_latched;
    reg  [3:0]  cmd_prev;
    reg  [1:0]  irq_stat;
    reg  [1:0]  irq_mask;
    reg  [15:0] chain_reg;
    reg  [`UVOL_GATE_CNT_W-1:0] gate_cnt [0:3];
    reg  [3:0]  gate_off;
    reg  [3:0]  next_out;
    reg         next_fault_n;
    wire [6:0]  cmp_s;
    wire        uv_s;
    wire        por_s;
    wire        low25_s;
    wire [3:0]  ol_s;
    wire [3:0]  cmd;
    wire [3:0]  cmd_rise;
    wire        acc;
    wire        wr;
    wire        rd;
    wire        status_read;
    wire [3:0]  ol_event;
    wire        uv_event;
    wire        uv_active;
    wire        wr_ctrl;
    wire        wr_irq_stat;
    wire        wr_irq_mask;
    wire [1:0]  irq_event;
    reg  [31:0] next_prdata;

    function mapped;
        input [11:0] a;
        begin
            case (a)
                `UVOL_ADDR_CTRL,
                `UVOL_ADDR_STATUS,
                `UVOL_ADDR_IRQ_STAT,
                `UVOL_ADDR_IRQ_MASK,
                `UVOL_ADDR_LIVE,
                `UVOL_ADDR_CHAIN: mapped = 1'b1;
                default:          mapped = 1'b0;
            endcase
        end
    endfunction

    // comparators are asynchronous to pclk
    uvol_sync #(.W(7)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({open_load_cmp, battery_low25, battery_por, battery_uv}),
        .q       (cmp_s)
    );
    assign uv_s    = cmp_s[0];
    assign por_s   = cmp_s[1];
    assign low25_s = cmp_s[2];
    assign ol_s    = cmp_s[6:3];

    assign pready      = 1'b1;
    assign acc         = psel & penable;
    assign pslverr     = acc & ~mapped(paddr);
    assign wr          = acc & pwrite & mapped(paddr);
    assign rd          = acc & ~pwrite & mapped(paddr);
    assign status_read = rd & (paddr == `UVOL_ADDR_STATUS);
    assign wr_ctrl     = wr & (paddr == `UVOL_ADDR_CTRL);
    assign wr_irq_stat = wr & (paddr == `UVOL_ADDR_IRQ_STAT);
    assign wr_irq_mask = wr & (paddr == `UVOL_ADDR_IRQ_MASK);

    // serial or direct command, either one switches the output on
    assign cmd      = cmd_spi | direct_in;
    assign cmd_rise = cmd & ~cmd_prev;

    // uv protection acts only in the band between por and threshold
    assign uv_active = uv_s & ~undervoltage_protect_off & ~por_s;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_spi                  <= 4'h0;
            undervoltage_protect_off <= 1'b0;
            open_load_detect_off     <= 4'h0;
            irq_mask                 <= `UVOL_MASK_RESET;
        end else if (wr_ctrl) begin
            cmd_spi                  <= pwdata[`UVOL_CTRL_CMD_LSB +: 4];
            undervoltage_protect_off <= pwdata[`UVOL_CTRL_UVOFF];
            open_load_detect_off     <= pwdata[`UVOL_CTRL_OLOFF_LSB +: 4];
        end else if (wr_irq_mask) begin
            irq_mask <= pwdata[1:0];
        end
    end

    // gate discharge timers: open load sampled only after output fully off
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_gate
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gate_cnt[g] <= {`UVOL_GATE_CNT_W{1'b0}};
                    gate_off[g] <= 1'b0;
                end else if (output_enable[g]) begin
                    gate_cnt[g] <= {`UVOL_GATE_CNT_W{1'b0}};
                    gate_off[g] <= 1'b0;
                end else if (gate_cnt[g] == `UVOL_GATE_OFF_CYC - 1) begin
                    gate_off[g] <= 1'b1;
                end else begin
                    gate_cnt[g] <= gate_cnt[g] + 1'b1;
                end
            end
            assign ol_event[g] = gate_off[g] & ~output_enable[g] & ol_s[g] & ~open_load_detect_off[g];
        end
    endgenerate

    assign uv_event = uv_s | low25_s;

    // flags: event wins over the clear-on-read; registers survive uv
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undervoltage_flag <= 1'b0;
        end else if (uv_event) begin
            undervoltage_flag <= 1'b1;
        end else if (status_read) begin
            undervoltage_flag <= 1'b0;
        end
    end

    generate
        for (g = 0; g < 4; g = g + 1) begin : g_flag
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    open_load_flag[g] <= 1'b0;
                end else if (ol_event[g]) begin
                    open_load_flag[g] <= 1'b1;
                end else if (status_read) begin
                    open_load_flag[g] <= 1'b0;
                end
            end
            // set only while commanded on, so an idle output never latches
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    uv_latched[g] <= 1'b0;
                end else if (uv_active && cmd[g]) begin
                    uv_latched[g] <= 1'b1;
                end else if (!uv_active && cmd_rise[g]) begin
                    uv_latched[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_prev <= 4'h0;
        end else begin
            cmd_prev <= cmd;
        end
    end

    always @* begin
        next_out     = cmd & ~uv_latched;
        next_fault_n = 1'b1;
        if (uv_active) begin
            next_out     = 4'h0;
            next_fault_n = 1'b0;
        end
        if (|uv_latched)
            next_fault_n = 1'b0;
        if (|ol_event)
            next_fault_n = 1'b0;
        if (low25_s) begin
            next_out     = 4'h0;
            next_fault_n = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_enable <= 4'h0;
            fault_flag_n  <= 1'b1;
        end else begin
            output_enable <= next_out;
            fault_flag_n  <= next_fault_n;
        end
    end

    // daisy chain needs only the logic supply
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_reg <= 16'h0000;
            chain_so  <= 1'b0;
        end else if (chain_shift) begin
            chain_so  <= chain_reg[15];
            chain_reg <= {chain_reg[14:0], chain_si};
        end
    end

    assign irq_event[`UVOL_IRQ_UV] = uv_event;
    assign irq_event[`UVOL_IRQ_OL] = |ol_event;

    // set wins over write-one-to-clear so an event in the clearing cycle is kept
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_irq
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_stat[g] <= 1'b0;
                end else if (irq_event[g]) begin
                    irq_stat[g] <= 1'b1;
                end else if (wr_irq_stat && pwdata[g]) begin
                    irq_stat[g] <= 1'b0;
                end
            end
        end
    endgenerate
    assign irq = |(irq_stat & irq_mask);

    always @* begin
        next_prdata = 32'h00000000;
        case (paddr)
            `UVOL_ADDR_CTRL: begin
                next_prdata[`UVOL_CTRL_CMD_LSB +: 4]   = cmd_spi;
                next_prdata[`UVOL_CTRL_UVOFF]          = undervoltage_protect_off;
                next_prdata[`UVOL_CTRL_OLOFF_LSB +: 4] = open_load_detect_off;
            end
            `UVOL_ADDR_STATUS: begin
                next_prdata[`UVOL_ST_OL_LSB +: 4] = open_load_flag;
                next_prdata[`UVOL_ST_UV]          = undervoltage_flag;
            end
            `UVOL_ADDR_IRQ_STAT: begin
                next_prdata[1:0] = irq_stat;
            end
            `UVOL_ADDR_IRQ_MASK: begin
                next_prdata[1:0] = irq_mask;
            end
            `UVOL_ADDR_LIVE: begin
                next_prdata[`UVOL_LV_OUT_LSB +: 4] = output_enable;
                next_prdata[`UVOL_LV_FAULT]        = fault_flag_n;
                next_prdata[`UVOL_LV_UVLATCH]      = |uv_latched;
            end
            `UVOL_ADDR_CHAIN: begin
                next_prdata[15:0] = chain_reg;
            end
            default: begin
                next_prdata = 32'h00000000;
            end
        endcase
    end

    // captured in the setup cycle so a status read returns the flags before they clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end
endmodule

// ### verif/uvol_fault_assertions.sv
// port checker for the fault block
`timescale 1ns/10ps
module uvol_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        battery_uv,
    input wire        battery_low25,
    input wire [3:0]  open_load_cmp,
    input wire [3:0]  output_enable,
    input wire        fault_flag_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc_s; psel && penable; endsequence
    sequence low_s; battery_low25 [*4]; endsequence
    sequence calm_s; ($stable(output_enable) && $stable(fault_flag_n)) [*2]; endsequence
    bus_ready_a: assert property (pready) else $error("pready low");
    err_access_a: assert property (pslverr |-> acc_s) else $error("pslverr outside access");
    bad_read_a: assert property (psel && penable && !pwrite && paddr > 12'h014 |-> prdata == 32'h0 && pslverr)
        else $error("unmapped read not refused");
    wr_prdata_a: assert property (psel && pwrite |=> $stable(prdata)) else $error("prdata moved on write");
    low_off_a: assert property (low_s |-> output_enable == 4'h0 && fault_flag_n)
        else $error("outputs not off below 2.5 V");
    uv_sync_a: assert property ($rose(battery_uv) |=> calm_s) else $error("unsynchronised uv");
    pin_cause_a: assert property ($fell(fault_flag_n) |-> $past(battery_uv, 3) || $past(open_load_cmp, 3) != 4'h0)
        else $error("fault pin low without cause");
    en_rise_a: assert property ((output_enable & ~$past(output_enable)) != 4'h0 |-> !$past(battery_low25, 3))
        else $error("output on below 2.5 V");
endmodule
bind uvol_fault uvol_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .battery_uv, .battery_low25, .open_load_cmp, .output_enable, .fault_flag_n);

// ### verif/uvol_host.sv
// apb host model for the fault block
`timescale 1ns/10ps
module uvol_host (
    input  wire        pclk,
    output reg         psel = 1'b0,
    output reg         penable = 1'b0,
    output reg         pwrite = 1'b0,
    output reg  [11:0] paddr = 12'h0,
    output reg  [31:0] pwdata = 32'h0,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr
);
    task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep the old value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench for the fault block
`timescale 1ns/10ps
`include "uvol_regs.vh"
module tb_top;
    localparam [11:0] CT = `UVOL_ADDR_CTRL, ST = `UVOL_ADDR_STATUS, IS = `UVOL_ADDR_IRQ_STAT;
    localparam [11:0] IM = `UVOL_ADDR_IRQ_MASK, LV = `UVOL_ADDR_LIVE, CH = `UVOL_ADDR_CHAIN;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg  [3:0]  direct_in = 4'h0;
    reg         battery_uv = 1'b0;
    reg         battery_por = 1'b0;
    reg         battery_low25 = 1'b0;
    reg  [3:0]  open_load_cmp = 4'h0;
    reg         chain_si = 1'b0;
    reg         chain_shift = 1'b0;
    wire        psel, penable, pwrite, pready, pslverr, chain_so, fault_flag_n, irq;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0]  output_enable;
    reg  [31:0] rd;
    reg         er;
    int         errors = 0, n_compared = 0, ticks = 0;
    uvol_fault DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .direct_in, .battery_uv, .battery_por, .battery_low25, .open_load_cmp, .chain_si, .chain_shift,
        .chain_so, .output_enable, .fault_flag_n, .irq);
    uvol_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    initial forever #4 pclk = ~pclk;
    task chk(input string n, input [31:0] e, input [31:0] s);
        n_compared = n_compared + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        u_host.xfer(1'b1, a, d, rd, er);
    endtask
    task rdc(input string n, input [11:0] a, input [31:0] e);
        u_host.xfer(1'b0, a, 32'h0, rd, er);
        chk(n, e, rd);
    endtask
    // long enough for sync plus output register
    task pins(input [3:0] oe, input fn);
        repeat (6) @(posedge pclk);
        #1;
        chk("output_enable", {28'h0, oe}, {28'h0, output_enable});
        chk("fault_flag_n", {31'h0, fn}, {31'h0, fault_flag_n});
    endtask
    task irqc(input e);
        #1;
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task t_reset;
        rdc("ctrl", CT, 32'h0);
        rdc("mask", IM, 32'h0);
        rdc("live", LV, 32'h10);
        rdc("unmapped", 12'h020, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        $display("test reset done");
    endtask
    task t_latch(input ser);
        if (ser) wr(CT, 32'h1);
        else @(posedge pclk) direct_in <= 4'h1;
        pins(4'h1, 1'b1);
        @(posedge pclk) battery_uv <= 1'b1;
        pins(4'h0, 1'b0);
        rdc("uv flag", ST, 32'h10);
        @(posedge pclk) battery_uv <= 1'b0;
        pins(4'h0, 1'b0);
        if (ser) begin
            wr(CT, 32'h0);
            wr(CT, 32'h1);
        end else begin
            @(posedge pclk) direct_in <= 4'h0;
            repeat (4) @(posedge pclk);
            direct_in <= 4'h1;
        end
        pins(4'h1, 1'b1);
        rdc("uv held", ST, 32'h10);
        rdc("uv clear", ST, 32'h0);
        if (ser) wr(CT, 32'h0);
        else @(posedge pclk) direct_in <= 4'h0;
        pins(4'h0, 1'b1);
        $display("test latch done");
    endtask
    task t_unlatch;
        @(posedge pclk) battery_uv <= 1'b1;
        pins(4'h0, 1'b0);
        @(posedge pclk) battery_uv <= 1'b0;
        pins(4'h0, 1'b1);
        rdc("uv held", ST, 32'h10);
        rdc("uv clear", ST, 32'h0);
        $display("test unlatch done");
    endtask
    task t_uvoff;
        wr(CT, 32'h11);
        @(posedge pclk) battery_uv <= 1'b1;
        pins(4'h1, 1'b1);
        rdc("uv flag", ST, 32'h10);
        @(posedge pclk) battery_low25 <= 1'b1;
        battery_por <= 1'b1;
        pins(4'h0, 1'b1);
        rdc("uv low", ST, 32'h10);
        wr(CT, 32'h0);
        @(posedge pclk) battery_low25 <= 1'b0;
        battery_por <= 1'b0;
        battery_uv <= 1'b0;
        pins(4'h0, 1'b1);
        u_host.xfer(1'b0, ST, 32'h0, rd, er);
        $display("test uvoff done");
    endtask
    task t_ol;
        wr(CT, 32'h2);
        @(posedge pclk) open_load_cmp <= 4'h2;
        pins(4'h2, 1'b1);
        rdc("ol on", ST, 32'h0);
        wr(CT, 32'h0);
        repeat (100) @(posedge pclk);
        rdc("ol gate", ST, 32'h0);
        repeat (200) @(posedge pclk);
        rdc("ol set", ST, 32'h2);
        rdc("ol stays", ST, 32'h2);
        pins(4'h0, 1'b0);
        @(posedge pclk) open_load_cmp <= 4'h0;
        pins(4'h0, 1'b1);
        rdc("ol held", ST, 32'h2);
        rdc("ol clear", ST, 32'h0);
        wr(CT, 32'h200);
        @(posedge pclk) open_load_cmp <= 4'h2;
        repeat (300) @(posedge pclk);
        rdc("ol off", ST, 32'h0);
        pins(4'h0, 1'b1);
        @(posedge pclk) open_load_cmp <= 4'h0;
        wr(CT, 32'h0);
        $display("test open load done");
    endtask
    task t_irq;
        wr(IS, 32'h3);
        wr(IM, 32'h1);
        @(posedge pclk) battery_uv <= 1'b1;
        pins(4'h0, 1'b0);
        @(posedge pclk) battery_uv <= 1'b0;
        pins(4'h0, 1'b1);
        irqc(1'b1);
        wr(IM, 32'h0);
        irqc(1'b0);
        wr(IM, 32'h1);
        irqc(1'b1);
        rdc("mask", IM, 32'h1);
        wr(IS, 32'h1);
        irqc(1'b0);
        rdc("irq stat", IS, 32'h0);
        u_host.xfer(1'b0, ST, 32'h0, rd, er);
        $display("test irq done");
    endtask
    task t_chain;
        int i;
        wr(CT, 32'hF00);
        @(posedge pclk) battery_uv <= 1'b1;
        battery_por <= 1'b1;
        battery_low25 <= 1'b1;
        chain_shift <= 1'b1;
        for (i = 15; i >= 0; i--) begin
            chain_si <= 16'hA5C3 >> i;
            @(posedge pclk);
        end
        chain_shift <= 1'b0;
        rdc("chain", CH, 32'hA5C3);
        rdc("ctrl kept", CT, 32'hF00);
        @(posedge pclk) chain_shift <= 1'b1;
        chain_si <= 1'b0;
        @(posedge pclk) chain_shift <= 1'b0;
        #1;
        chk("chain_so", 32'h1, {31'h0, chain_so});
        @(posedge pclk) battery_uv <= 1'b0;
        battery_por <= 1'b0;
        battery_low25 <= 1'b0;
        wr(CT, 32'h0);
        $display("test chain done");
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        ticks <= ticks + 1;
        if (ticks == 6000) begin
            errors = errors + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_latch(1'b1);
        t_latch(1'b0);
        t_unlatch;
        t_uvoff;
        t_ol;
        t_irq;
        t_chain;
        give_verdict;
    end
endmodule
